// ==== logic/ov_oc_mismatch_defs.svh ====
// constants for the over-level, mismatch and trim block
`ifndef OV_OC_MISMATCH_DEFS_SVH
`define OV_OC_MISMATCH_DEFS_SVH
`define EV_OV_BIT 18
`define EV_OI_BIT 17
`define EV_MISMATCH_BIT 20
`define ST0_READY_BIT 17
`define PH_OV_LSB 9
`define PH_OI_LSB 3
`define HPF_FULL_SCALE 24'h5A7540
`define TRIM_LAG_OFFSET 10'h200
`define TRIM_LEAD_MAX 10'h17F
`define TRIM_LAG_MAX 10'h23F
`define TRIM_STEP_NS 976
`define TRIM_RATE_KHZ 1024
`define CLK_PERIOD_NS 10
`define TRIM_STEP_CYCLES ((`TRIM_STEP_NS) / (`CLK_PERIOD_NS))
`define MISMATCH_RESET 24'h000000
`define THRESH_RESET 24'h000000
`define TRIM_RESET 10'h000
`endif

// ==== logic/ov_oc_mismatch_phase_cal.sv ====
// over-level and neutral mismatch detectors with per-phase voltage trim
`timescale 1ns/1ps
`default_nettype none
`include "ov_oc_mismatch_defs.svh"

module ov_oc_mismatch_phase_cal (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// sample set from the datapath, one strobe per 8 kHz set
	input wire logic sample_valid,
	input var ov_oc_mismatch_pkg::sample_set_s samples,
	// register writes
	input wire logic [23:0] overvoltage_threshold,
	input wire logic [23:0] overcurrent_threshold,
	input wire logic [23:0] sum_mismatch_threshold,
	input var ov_oc_mismatch_pkg::trim_set_s per_phase_path_trim,
	input wire logic [31:0] event_mask_reg,
	input wire logic [31:0] second_mask_reg,
	input wire logic event_status_wr,
	input wire logic [31:0] event_status_wdata,
	input wire logic second_status_wr,
	input wire logic [31:0] second_status_wdata,
	input wire logic neutral_source_select,
	// register read views
	output logic [31:0] event_status_reg,
	output logic [15:0] phase_status_reg,
	output logic [31:0] second_status_reg,
	output logic [31:0] overvoltage_threshold_rd,
	output logic [31:0] overcurrent_threshold_rd,
	output logic [31:0] phase_current_sum_rd,
	output logic [31:0] sum_mismatch_threshold_rd,
	output logic [15:0] phase_a_path_trim_rd,
	output logic [15:0] phase_b_path_trim_rd,
	output logic [15:0] phase_c_path_trim_rd,
	output logic [27:0] neutral_rms_result,
	// trimmed voltage path
	output logic trim_step_tick,
	output ov_oc_mismatch_pkg::trim_set_s applied_trim,
	// interrupts
	output logic event_irq_n,
	output logic second_irq_n
);

	logic [2:0] ov_hit;
	logic [2:0] oi_hit;
	logic [2:0] overvoltage_phase_flags_ff;
	logic [2:0] overcurrent_phase_flags_ff;
	logic overvoltage_flag_ff;
	logic overcurrent_flag_ff;
	logic neutral_mismatch_flag_ff;
	logic sample_ready_flag_ff;
	logic [27:0] phase_current_sum_ff;
	logic [27:0] nxt_sum;
	logic [27:0] sum_mag;
	logic [27:0] neu_mag;
	logic [27:0] diff_mag;
	logic [27:0] lvl_ext;
	logic mismatch_hit;
	logic clr_ov;
	logic clr_oi;
	logic clr_mm;
	logic clr_rdy;
	logic [27:0] rms_ff;
	logic [6:0] step_cnt_ff;
	logic step_tick_ff;
	logic [9:0] trim_req [3];
	logic [9:0] applied_ph_ff [3];

	function automatic logic [23:0] abs24(input logic [23:0] v);
		abs24 = v[23] ? 24'(-v) : v;
	endfunction

	// lead codes up to 383 steps, lag codes 512 plus up to 63 steps
	function automatic logic trim_code_ok(input logic [9:0] code);
		trim_code_ok = (code <= `TRIM_LEAD_MAX) || ((code >= `TRIM_LAG_OFFSET) && (code <= `TRIM_LAG_MAX));
	endfunction

	// per-phase magnitude compare
	logic [23:0] vsel [3];
	logic [23:0] isel [3];
	assign vsel[0] = samples.va;
	assign vsel[1] = samples.vb;
	assign vsel[2] = samples.vc;
	assign isel[0] = samples.ia;
	assign isel[1] = samples.ib;
	assign isel[2] = samples.ic;
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_phase
			// full-scale threshold is never exceeded by in-range samples; zero is exceeded by any nonzero sample
			assign ov_hit[g] = sample_valid && (abs24(vsel[g]) > overvoltage_threshold);
			assign oi_hit[g] = sample_valid && (abs24(isel[g]) > overcurrent_threshold);
		end
	endgenerate

	assign clr_ov = event_status_wr && event_status_wdata[`EV_OV_BIT];
	assign clr_oi = event_status_wr && event_status_wdata[`EV_OI_BIT];
	assign clr_mm = event_status_wr && event_status_wdata[`EV_MISMATCH_BIT];
	assign clr_rdy = second_status_wr && second_status_wdata[`ST0_READY_BIT];

	// overvoltage flags, set wins over clear
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			overvoltage_flag_ff <= 1'b0;
			overvoltage_phase_flags_ff <= 3'h0;
		end
		else
		begin
			overvoltage_flag_ff <= (|ov_hit) | (overvoltage_flag_ff & ~clr_ov);
			overvoltage_phase_flags_ff <= ov_hit | (overvoltage_phase_flags_ff & {3{~clr_ov}});
		end
	end

	// overcurrent flags
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			overcurrent_flag_ff <= 1'b0;
			overcurrent_phase_flags_ff <= 3'h0;
		end
		else
		begin
			overcurrent_flag_ff <= (|oi_hit) | (overcurrent_flag_ff & ~clr_oi);
			overcurrent_phase_flags_ff <= oi_hit | (overcurrent_phase_flags_ff & {3{~clr_oi}});
		end
	end

	// current sum and data ready
	assign nxt_sum = 28'(signed'(samples.ia)) + 28'(signed'(samples.ib)) + 28'(signed'(samples.ic));
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			phase_current_sum_ff <= 28'h0000000;
			sample_ready_flag_ff <= 1'b0;
		end
		else
		begin
			if (sample_valid)
				phase_current_sum_ff <= nxt_sum;
			sample_ready_flag_ff <= sample_valid | (sample_ready_flag_ff & ~clr_rdy);
		end
	end

	// mismatch on the fresh sum
	assign sum_mag = nxt_sum[27] ? 28'(-nxt_sum) : nxt_sum;
	assign neu_mag = {4'h0, abs24(samples.in)};
	assign diff_mag = (sum_mag > neu_mag) ? 28'(sum_mag - neu_mag) : 28'(neu_mag - sum_mag);
	assign lvl_ext = 28'(signed'(sum_mismatch_threshold));
	// negative threshold always fires; zero fires on any nonzero difference
	assign mismatch_hit = sample_valid && (lvl_ext[27] || (diff_mag > lvl_ext));
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			neutral_mismatch_flag_ff <= 1'b0;
		else
			neutral_mismatch_flag_ff <= mismatch_hit | (neutral_mismatch_flag_ff & ~clr_mm);
	end

	// averaged magnitude of the sum, square-root-free
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			rms_ff <= 28'h0000000;
		end
		else if (sample_valid && neutral_source_select)
		begin
			rms_ff <= 28'(rms_ff - (rms_ff >> 8) + (sum_mag >> 8));
		end
	end

	// trim step tick every 97 clocks (970 ns)
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			step_cnt_ff <= 7'h00;
			step_tick_ff <= 1'b0;
		end
		else
		begin
			step_tick_ff <= (step_cnt_ff == 7'(`TRIM_STEP_CYCLES - 1));
			step_cnt_ff <= (step_cnt_ff == 7'(`TRIM_STEP_CYCLES - 1)) ? 7'h00 : 7'(step_cnt_ff + 7'h01);
		end
	end

	// trims take effect on a step boundary; out-of-range codes keep the old trim
	assign trim_req[0] = per_phase_path_trim.a;
	assign trim_req[1] = per_phase_path_trim.b;
	assign trim_req[2] = per_phase_path_trim.c;
	generate
		for (g = 0; g < 3; g++)
		begin : g_trim
			always_ff @(posedge clk or posedge reset)
			begin
				if (reset)
					applied_ph_ff[g] <= `TRIM_RESET;
				else if (step_tick_ff && trim_code_ok(trim_req[g]))
					applied_ph_ff[g] <= trim_req[g];
			end
		end
	endgenerate

	assign trim_step_tick = step_tick_ff;
	assign applied_trim = {applied_ph_ff[0], applied_ph_ff[1], applied_ph_ff[2]};
	assign neutral_rms_result = rms_ff;

	always_comb
	begin
		event_status_reg = 32'h0;
		event_status_reg[`EV_OV_BIT] = overvoltage_flag_ff;
		event_status_reg[`EV_OI_BIT] = overcurrent_flag_ff;
		event_status_reg[`EV_MISMATCH_BIT] = neutral_mismatch_flag_ff;
		phase_status_reg = 16'h0;
		phase_status_reg[`PH_OV_LSB +: 3] = overvoltage_phase_flags_ff;
		phase_status_reg[`PH_OI_LSB +: 3] = overcurrent_phase_flags_ff;
		second_status_reg = 32'h0;
		second_status_reg[`ST0_READY_BIT] = sample_ready_flag_ff;
	end

	assign overvoltage_threshold_rd = {8'h00, overvoltage_threshold};
	assign overcurrent_threshold_rd = {8'h00, overcurrent_threshold};
	assign phase_current_sum_rd = {4'h0, phase_current_sum_ff};
	assign sum_mismatch_threshold_rd = {4'h0, lvl_ext};
	assign phase_a_path_trim_rd = {6'h00, per_phase_path_trim.a};
	assign phase_b_path_trim_rd = {6'h00, per_phase_path_trim.b};
	assign phase_c_path_trim_rd = {6'h00, per_phase_path_trim.c};

	assign event_irq_n = ~((overvoltage_flag_ff & event_mask_reg[`EV_OV_BIT])
		| (overcurrent_flag_ff & event_mask_reg[`EV_OI_BIT])
		| (neutral_mismatch_flag_ff & event_mask_reg[`EV_MISMATCH_BIT]));
	assign second_irq_n = ~(sample_ready_flag_ff & second_mask_reg[`ST0_READY_BIT]);

	a_ov_flag_set: assert property (@(posedge clk) disable iff (reset)
		(|ov_hit) |=> overvoltage_flag_ff)
		else $error("ov flag not set");
	a_ov_irq_low: assert property (@(posedge clk) disable iff (reset)
		((|ov_hit) && event_mask_reg[`EV_OV_BIT]) |=> !event_irq_n)
		else $error("irq not low");
	a_ov_clear: assert property (@(posedge clk) disable iff (reset)
		(clr_ov && !(|ov_hit)) |=> (!overvoltage_flag_ff && overvoltage_phase_flags_ff == 3'h0))
		else $error("ov not cleared");
	a_oi_phase: assert property (@(posedge clk) disable iff (reset)
		oi_hit[0] |=> phase_status_reg[`PH_OI_LSB])
		else $error("oi phase missing");
	a_oi_irq_low: assert property (@(posedge clk) disable iff (reset)
		((|oi_hit) && event_mask_reg[`EV_OI_BIT]) |=> !event_irq_n)
		else $error("oi irq not low");
	a_oi_clear: assert property (@(posedge clk) disable iff (reset)
		(clr_oi && !(|oi_hit)) |=> (!overcurrent_flag_ff && overcurrent_phase_flags_ff == 3'h0))
		else $error("oi not cleared");
	a_full_scale: assert property (@(posedge clk) disable iff (reset)
		(overvoltage_threshold == `HPF_FULL_SCALE && !samples.va[23] && samples.va <= `HPF_FULL_SCALE) |-> !ov_hit[0])
		else $error("full scale hit");
	a_zero_thresh: assert property (@(posedge clk) disable iff (reset)
		(sample_valid && overcurrent_threshold == 24'h0 && samples.ia != 24'h0) |=> overcurrent_flag_ff)
		else $error("zero thresh miss");
	a_sum_store: assert property (@(posedge clk) disable iff (reset)
		sample_valid |=> (phase_current_sum_ff == $past(nxt_sum) && sample_ready_flag_ff))
		else $error("sum wrong");
	a_mm_clear: assert property (@(posedge clk) disable iff (reset)
		(clr_mm && !mismatch_hit) |=> !neutral_mismatch_flag_ff)
		else $error("mismatch not cleared");
	a_mm_zero: assert property (@(posedge clk) disable iff (reset)
		(sample_valid && sum_mismatch_threshold == 24'h0 && diff_mag != 28'h0) |=> neutral_mismatch_flag_ff)
		else $error("mismatch miss");
	a_trim_refused: assert property (@(posedge clk) disable iff (reset)
		(step_tick_ff && !trim_code_ok(trim_req[0])) |=> $stable(applied_ph_ff[0]))
		else $error("bad trim applied");
	a_rdy_clear: assert property (@(posedge clk) disable iff (reset)
		(clr_rdy && !sample_valid) |=> second_irq_n)
		else $error("ready irq stuck");

endmodule
`default_nettype wire

// ==== logic/ov_oc_mismatch_pkg.sv ====
// types for the over-level, mismatch and trim block
package ov_oc_mismatch_pkg;
	typedef struct packed {
		logic [23:0] va;
		logic [23:0] vb;
		logic [23:0] vc;
		logic [23:0] ia;
		logic [23:0] ib;
		logic [23:0] ic;
		logic [23:0] in;
	} sample_set_s;
	typedef struct packed {
		logic [9:0] a;
		logic [9:0] b;
		logic [9:0] c;
	} trim_set_s;
endpackage

// ==== tb/ov_oc_mismatch_phase_cal_tb_top.sv ====
// self-checking bench for the over-level, mismatch and trim block
`timescale 1ns/1ps
`default_nettype none
`include "ov_oc_mismatch_defs.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
	$display("BAD t=%0t got %h exp %h", $time, a, e); end end
module ov_oc_mismatch_phase_cal_tb_top;
	logic clk = 0;
	logic reset = 1;
	logic sample_valid = 0;
	logic ev_wr = 0;
	logic s_wr = 0;
	logic nsel = 0;
	ov_oc_mismatch_pkg::sample_set_s samples = '0;
	ov_oc_mismatch_pkg::trim_set_s trims = '0;
	ov_oc_mismatch_pkg::trim_set_s applied;
	logic [23:0] ov_thr = '0, oi_thr = '0, mm_thr = '0;
	logic [31:0] ev_mask = '0, s_mask = '0, ev_wdata = '0, s_wdata = '0;
	logic [31:0] ev_st, s_st, ov_rd, oi_rd, sum_rd, mm_rd;
	logic [15:0] ph_st, ta_rd, tb_rd, tc_rd;
	logic tick, irq_n, irq2_n, ov_f, oi_f, mm_f, rdy_f;
	logic [2:0] ovp, oip;
	logic [27:0] exp_sum, rms;
	logic [27:0] exp_rms = '0;
	ov_oc_mismatch_pkg::trim_set_s exp_trim;
	logic [31:0] seed = 32'h08406C0D;
	int n_mismatch = 0;
	int tests_run = 0;
	int k;
	always #5 clk = ~clk;
	ov_oc_mismatch_phase_cal uut (.clk(clk), .reset(reset), .sample_valid(sample_valid), .samples(samples),
		.overvoltage_threshold(ov_thr), .overcurrent_threshold(oi_thr), .sum_mismatch_threshold(mm_thr),
		.per_phase_path_trim(trims), .event_mask_reg(ev_mask), .second_mask_reg(s_mask),
		.event_status_wr(ev_wr), .event_status_wdata(ev_wdata), .second_status_wr(s_wr),
		.second_status_wdata(s_wdata), .neutral_source_select(nsel), .event_status_reg(ev_st),
		.phase_status_reg(ph_st), .second_status_reg(s_st), .overvoltage_threshold_rd(ov_rd),
		.overcurrent_threshold_rd(oi_rd), .phase_current_sum_rd(sum_rd), .sum_mismatch_threshold_rd(mm_rd),
		.phase_a_path_trim_rd(ta_rd), .phase_b_path_trim_rd(tb_rd), .phase_c_path_trim_rd(tc_rd),
		.neutral_rms_result(rms), .trim_step_tick(tick), .applied_trim(applied), .event_irq_n(irq_n),
		.second_irq_n(irq2_n));
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function int iabs(input int x);
		return (x < 0) ? -x : x;
	endfunction
	// corner samples at full scale either sign, or zero
	function logic [23:0] pick(input logic corner);
		logic [31:0] r;
		r = rnd();
		if (!corner)
			return r[23:0];
		return (r % 3 == 0) ? `HPF_FULL_SCALE : ((r % 3 == 1) ? 24'hA58AC0 : 24'h000000);
	endfunction
	function logic [9:0] trim_code();
		logic [31:0] r;
		r = rnd();
		return r[0] ? 10'(r % 384) : 10'(`TRIM_LAG_OFFSET + 1 + (r % 63));
	endfunction
	task automatic check_all();
		`CHK(ev_st[18], ov_f)
		`CHK(ph_st[11:9], ovp)
		`CHK(ev_st[17], oi_f)
		`CHK(ph_st[5:3], oip)
		`CHK(ev_st[20], mm_f)
		`CHK(s_st[17], rdy_f)
		`CHK(irq_n, !((ov_f && ev_mask[18]) || (oi_f && ev_mask[17]) || (mm_f && ev_mask[20])))
		`CHK(irq2_n, !(rdy_f && s_mask[17]))
		`CHK(ov_rd, {8'h00, ov_thr})
		`CHK(oi_rd, {8'h00, oi_thr})
		`CHK(mm_rd, {4'h0, {4{mm_thr[23]}}, mm_thr})
		`CHK({ta_rd, tb_rd, tc_rd}, {6'h00, trims.a, 6'h00, trims.b, 6'h00, trims.c})
	endtask
	task automatic send_sample(input ov_oc_mismatch_pkg::sample_set_s s);
		logic [23:0] v[3];
		logic [23:0] c[3];
		int d;
		logic [27:0] m;
		v = '{s.va, s.vb, s.vc};
		c = '{s.ia, s.ib, s.ic};
		@(posedge clk);
		sample_valid <= 1;
		samples <= s;
		@(posedge clk);
		sample_valid <= 0;
		for (int p = 0; p < 3; p++)
		begin
			if (iabs(int'($signed(v[p]))) > int'(ov_thr))
			begin
				ov_f = 1;
				ovp[p] = 1;
			end
			if (iabs(int'($signed(c[p]))) > int'(oi_thr))
			begin
				oi_f = 1;
				oip[p] = 1;
			end
		end
		exp_sum = {{4{s.ia[23]}}, s.ia} + {{4{s.ib[23]}}, s.ib} + {{4{s.ic[23]}}, s.ic};
		m = exp_sum[27] ? 28'(-exp_sum) : exp_sum;
		if (nsel)
			exp_rms = exp_rms - (exp_rms >> 8) + (m >> 8);
		d = iabs(iabs(int'($signed(exp_sum))) - iabs(int'($signed(s.in))));
		if (mm_thr[23] || d > int'(mm_thr))
			mm_f = 1;
		rdy_f = 1;
		@(negedge clk);
		check_all();
		`CHK(sum_rd, {4'h0, exp_sum})
		`CHK(rms, exp_rms)
	endtask
	task automatic clear(input logic [31:0] r);
		@(posedge clk);
		ev_wr <= 1;
		s_wr <= 1;
		ev_wdata <= {11'h000, r[2], 1'b0, r[1], r[0], 17'h00000};
		s_wdata <= {14'h0000, r[3], 17'h00000};
		@(posedge clk);
		ev_wr <= 0;
		s_wr <= 0;
		if (r[2]) mm_f = 0;
		if (r[1]) {ov_f, ovp} = '0;
		if (r[0]) {oi_f, oip} = '0;
		if (r[3]) rdy_f = 0;
		@(negedge clk);
		check_all();
	endtask
	task automatic wait_tick(output int n);
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end while (tick !== 1'b1 && n < 300);
		if (n >= 300)
		begin
			n_mismatch++;
			finish_test();
		end
	endtask
	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		{ov_f, oi_f, mm_f, rdy_f, ovp, oip} = '0;
		repeat (3) @(posedge clk);
		reset <= 0;
		@(negedge clk);
		check_all();
		for (int i = 0; i < 48; i++)
		begin
			@(posedge clk);
			ov_thr <= (i % 4 == 0) ? (rnd() % 2 ? `HPF_FULL_SCALE : 24'h000000) : rnd();
			oi_thr <= (i % 4 == 2) ? (rnd() % 2 ? `HPF_FULL_SCALE : 24'h000000) : rnd();
			mm_thr <= (i == 5) ? 24'hFFFFFF : ((i % 4 == 1) ? 24'h000000 : {1'b0, 23'(rnd())});
			ev_mask <= rnd();
			s_mask <= rnd();
			nsel <= rnd();
			trims <= {trim_code(), trim_code(), trim_code()};
			send_sample({pick(i % 4 == 0), pick(i % 4 == 0), pick(i % 4 == 0), pick(i % 4 == 2),
				pick(i % 4 == 2), pick(i % 4 == 2), pick(0)});
			clear(rnd());
		end
		wait_tick(k);
		wait_tick(k);
		`CHK(k, `TRIM_STEP_CYCLES)
		repeat (2) @(negedge clk);
		`CHK(applied, trims)
		exp_trim = trims;
		@(posedge clk);
		trims <= {10'h3FF, trim_code(), trims.c};
		wait_tick(k);
		wait_tick(k);
		repeat (2) @(negedge clk);
		`CHK(applied.a, exp_trim.a)
		`CHK(applied.b, trims.b)
		finish_test();
	end
endmodule
`default_nettype wire
